// ---- rbs_pkg.sv ----
// Constants, register map and carrier types for the read burst sequencer
package rbs_pkg;
	localparam logic [7:0] RBS_MODE_OFFSET = 8'h00;
	localparam logic [7:0] RBS_STATUS_OFFSET = 8'h04;
	localparam logic [7:0] RBS_COUNT_OFFSET = 8'h08;
	localparam int RBS_BL_LSB = 0;
	localparam int RBS_RPRE_BIT = 2;
	localparam int RBS_WPRE_BIT = 3;
	localparam int RBS_RL_LSB = 8;
	localparam int RBS_WL_LSB = 16;
	localparam int RBS_ST_SPACING_BIT = 0;
	localparam int RBS_ST_WL_LOW_BIT = 1;
	localparam int RBS_ST_RD_BIT = 2;
	localparam int RBS_ST_WR_BIT = 3;
	localparam logic [1:0] RBS_BL_FIXED8 = 2'h0;
	localparam logic [1:0] RBS_BL_PER_CMD = 2'h1;
	localparam logic [1:0] RBS_BL_FIXED4 = 2'h2;
	localparam logic [4:0] RBS_RL_RESET = 5'h0B;
	localparam logic [4:0] RBS_WL_RESET = 5'h09;
	localparam logic [4:0] RBS_CWL_LOWEST = 5'h09;
	localparam logic [3:0] RBS_FORBIDDEN_GAP = 4'h5;
	localparam logic [3:0] RBS_GAP_MAX = 4'hF;
	localparam logic [2:0] RBS_PAIRS_FULL = 3'h4;
	localparam logic [2:0] RBS_PAIRS_CHOP = 3'h2;
	localparam int RBS_DEPTH = 32;
	localparam logic [31:0] RBS_MODE_RESET = 32'h0009_0B00;

	// Column command as seen on the command pins
	typedef struct packed {
		logic valid;
		logic write;
		logic chop_select_address_bit;
		logic [1:0] bank_group;
	} rbs_cmd_t;

	// Entry of the latency delay line
	typedef struct packed {
		logic valid;
		logic write;
		logic chopped;
	} rbs_slot_t;

	typedef enum logic [1:0] {
		RBS_IDLE = 2'b00,
		RBS_BURST = 2'b01
	} rbs_state_t;
endpackage : rbs_pkg

// ---- rbs_read_burst_sequencing.sv ----
// Read and write burst sequencing with APB mode and status registers
//
// Contract
// - Field 00 forces eight-beat bursts always
// - Field 01, chop bit high: eight beats
// - Field 01, chop bit low: four beats
// - Field 10 forces chopped four-beat bursts
`timescale 1ns/1ps
module rbs_read_burst_sequencing
	import rbs_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire rbs_pkg::rbs_cmd_t cmd_pins,
	output logic rd_drive,
	output logic [1:0] rd_pair_index,
	output logic rd_chopped,
	output logic wr_capture,
	output logic [1:0] wr_pair_index,
	output logic wr_chopped
);
	import rbs_pkg::*;

	rbs_cmd_t cmd_meta_reg;
	rbs_cmd_t cmd_sync_reg;
	logic [31:0] mode_register_zero;
	logic spacing_err_reg;
	logic [31:0] read_count_reg;
	logic [3:0] gap_reg;
	rbs_slot_t line_reg [0:RBS_DEPTH-1];
	rbs_state_t rd_state_reg;
	rbs_state_t wr_state_reg;
	logic [2:0] rd_left_reg;
	logic [2:0] wr_left_reg;

	// Mode fields
	wire [1:0] burst_field = mode_register_zero[RBS_BL_LSB +: 2];
	wire read_pre_long = mode_register_zero[RBS_RPRE_BIT];
	wire write_pre_long = mode_register_zero[RBS_WPRE_BIT];
	wire [4:0] read_latency = mode_register_zero[RBS_RL_LSB +: 5];
	wire [4:0] write_latency = mode_register_zero[RBS_WL_LSB +: 5];

	// Burst length decision, used for both reads and writes
	function automatic logic rbs_is_chopped(input logic [1:0] field, input logic chop_bit);
		logic r;
		r = 1'b0;
		if (field == RBS_BL_FIXED8)
			r = 1'b0;
		else if (field == RBS_BL_PER_CMD)
			r = ~chop_bit;
		else if (field == RBS_BL_FIXED4)
			r = 1'b1;
		return r;
	endfunction : rbs_is_chopped

	// Command pins come from another domain, so two flops first
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cmd_meta_reg <= '0;
			cmd_sync_reg <= '0;
		end
		else
		begin
			cmd_meta_reg <= cmd_pins;
			cmd_sync_reg <= cmd_meta_reg;
		end
	end

	// Command classification
	wire cmd_read = cmd_sync_reg.valid & ~cmd_sync_reg.write;
	wire cmd_chopped = rbs_is_chopped(burst_field, cmd_sync_reg.chop_select_address_bit);
	// five-clock spacing under long preamble is a controller fault
	wire spacing_hit = cmd_read & read_pre_long & (gap_reg == RBS_FORBIDDEN_GAP);
	// advisory, live status only since the device still works
	wire wl_low = write_pre_long & (write_latency <= RBS_CWL_LOWEST);

	// Clocks since the previous read, saturating
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			gap_reg <= RBS_GAP_MAX;
		else if (cmd_read)
			gap_reg <= 4'h1;
		else if (gap_reg != RBS_GAP_MAX)
			gap_reg <= gap_reg + 4'h1;
	end

	// Latency delay line; entry 0 is one clock after the command
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < RBS_DEPTH; i++)
				line_reg[i] <= '0;
		end
		else
		begin
			line_reg[0] <= '{cmd_sync_reg.valid, cmd_sync_reg.write, cmd_chopped};
			for (int i = 1; i < RBS_DEPTH; i++)
				line_reg[i] <= line_reg[i-1];
		end
	end

	// Taps at the programmed latencies; latency 0 taken as 1
	wire [4:0] rd_tap = (read_latency == 5'h00) ? 5'h00 : read_latency - 5'h01;
	wire [4:0] wr_tap = (write_latency == 5'h00) ? 5'h00 : write_latency - 5'h01;
	wire rbs_slot_t rd_slot = line_reg[rd_tap];
	wire rbs_slot_t wr_slot = line_reg[wr_tap];
	wire rd_start = rd_slot.valid & ~rd_slot.write;
	wire wr_start = wr_slot.valid & wr_slot.write;
	wire [2:0] rd_pairs = rd_slot.chopped ? RBS_PAIRS_CHOP : RBS_PAIRS_FULL;
	wire [2:0] wr_pairs = wr_slot.chopped ? RBS_PAIRS_CHOP : RBS_PAIRS_FULL;

	// Read data engine, two beats per clock
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rd_state_reg <= RBS_IDLE;
			rd_left_reg <= 3'h0;
			rd_drive <= 1'b0;
			rd_pair_index <= 2'h0;
			rd_chopped <= 1'b0;
		end
		// a new start on the last pair continues without a gap
		else if (rd_start)
		begin
			rd_state_reg <= RBS_BURST;
			rd_left_reg <= rd_pairs - 3'h1;
			rd_drive <= 1'b1;
			rd_pair_index <= 2'h0;
			rd_chopped <= rd_slot.chopped;
		end
		else if (rd_state_reg == RBS_BURST && rd_left_reg != 3'h0)
		begin
			rd_left_reg <= rd_left_reg - 3'h1;
			rd_pair_index <= rd_pair_index + 2'h1;
		end
		else
		begin
			rd_state_reg <= RBS_IDLE;
			rd_drive <= 1'b0;
			rd_pair_index <= 2'h0;
		end
	end

	// Write capture engine, same pairing as reads
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wr_state_reg <= RBS_IDLE;
			wr_left_reg <= 3'h0;
			wr_capture <= 1'b0;
			wr_pair_index <= 2'h0;
			wr_chopped <= 1'b0;
		end
		else if (wr_start)
		begin
			wr_state_reg <= RBS_BURST;
			wr_left_reg <= wr_pairs - 3'h1;
			wr_capture <= 1'b1;
			wr_pair_index <= 2'h0;
			wr_chopped <= wr_slot.chopped;
		end
		else if (wr_state_reg == RBS_BURST && wr_left_reg != 3'h0)
		begin
			wr_left_reg <= wr_left_reg - 3'h1;
			wr_pair_index <= wr_pair_index + 2'h1;
		end
		else
		begin
			wr_state_reg <= RBS_IDLE;
			wr_capture <= 1'b0;
			wr_pair_index <= 2'h0;
		end
	end

	// APB decode; answer in the cycle after setup
	wire apb_setup = psel & ~penable;
	wire apb_commit = psel & penable & pready;
	wire hit_mode = (paddr[7:0] == RBS_MODE_OFFSET) && (paddr[31:8] == 24'h000000);
	wire hit_status = (paddr[7:0] == RBS_STATUS_OFFSET) && (paddr[31:8] == 24'h000000);
	wire hit_count = (paddr[7:0] == RBS_COUNT_OFFSET) && (paddr[31:8] == 24'h000000);
	wire hit_any = hit_mode | hit_status | hit_count;
	wire [31:0] status_word = {28'h0000000, wr_capture, rd_drive, wl_low, spacing_err_reg};
	wire [31:0] read_mux = hit_mode ? mode_register_zero :
		hit_status ? status_word :
		hit_count ? read_count_reg : 32'h00000000;
	wire clear_spacing = apb_commit & pwrite & hit_status & pwdata[RBS_ST_SPACING_BIT];

	// Bus answer flops
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end
		else
		begin
			pready <= apb_setup;
			pslverr <= apb_setup & ~hit_any;
			prdata <= (apb_setup & ~pwrite) ? read_mux : 32'h00000000;
		end
	end

	// Registers; a spacing fault in the clearing cycle wins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode_register_zero <= RBS_MODE_RESET;
			spacing_err_reg <= 1'b0;
			read_count_reg <= 32'h00000000;
		end
		else
		begin
			if (apb_commit & pwrite & hit_mode)
				mode_register_zero <= pwdata & 32'h001F_1F0F;
			if (spacing_hit)
				spacing_err_reg <= 1'b1;
			else if (clear_spacing)
				spacing_err_reg <= 1'b0;
			if (cmd_read)
				read_count_reg <= read_count_reg + 32'h00000001;
		end
	end
endmodule : rbs_read_burst_sequencing

// ---- rbs_chk_assertions.sv ----
// Port assertions for the burst sequencer
`timescale 1ns/1ps
module rbs_chk
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic rd_drive,
	input wire logic [1:0] rd_pair_index,
	input wire logic rd_chopped,
	input wire logic wr_capture,
	input wire logic [1:0] wr_pair_index,
	input wire logic wr_chopped
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Burst lengths per kind; after a chopped last pair or a full read's last pair the burst stops or restarts
	chk_full_read: assert property ($rose(rd_drive) && !rd_chopped |-> rd_drive[*4])
		else $error("full read cut short");
	chk_chop_read: assert property (rd_drive && rd_chopped && rd_pair_index == 2'h1
		|=> !rd_drive || rd_pair_index == 2'h0) else $error("chopped read too long");
	chk_full_write: assert property ($rose(wr_capture) && !wr_chopped |-> wr_capture[*4])
		else $error("full write cut short");
	chk_chop_write: assert property (wr_capture && wr_chopped && wr_pair_index == 2'h1
		|=> !wr_capture || wr_pair_index == 2'h0) else $error("chopped write too long");
	chk_read_stream: assert property (rd_drive && !rd_chopped && rd_pair_index == 2'h3
		|=> !rd_drive || rd_pair_index == 2'h0) else $error("read stream out of order");
endmodule : rbs_chk

bind rbs_read_burst_sequencing rbs_chk rbs_chk_i (.pclk, .presetn, .rd_drive, .rd_pair_index,
	.rd_chopped, .wr_capture, .wr_pair_index, .wr_chopped);

// ---- rbs_ctrl_model.sv ----
// Controller model that issues column commands
`timescale 1ns/1ps
module rbs_ctrl_model
	import rbs_pkg::*;
(
	input wire logic pclk,
	output rbs_pkg::rbs_cmd_t cmd_pins
);
	initial cmd_pins = '0;
	// One command, gap clocks after the previous one; a gap of 5 becomes 6
	task automatic issue(input logic w, c, input logic [1:0] g, input int gap);
		if (gap == 5)
			gap = 6;
		repeat (gap - 1) @(posedge pclk);
		cmd_pins <= '{1'b1, w, c, g};
		@(posedge pclk);
		// Released pins show the inverse, not stale values
		cmd_pins <= '{1'b0, ~w, ~c, ~g};
	endtask : issue
endmodule : rbs_ctrl_model

// ---- tb_read_burst_sequencing.sv ----
// Bench for the burst sequencer
`timescale 1ns/1ps
module tb_read_burst_sequencing;
	import rbs_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, p;
	logic rd_drive, rd_chopped, wr_capture, wr_chopped;
	logic [1:0] rd_pair_index, wr_pair_index;
	logic [31:0] paddr, pwdata, prdata, rnd;
	logic [32:0] qa[$], qr[$], qw[$];
	rbs_cmd_t cmd_pins;
	int miscompares, total_checks, n, r, k;
	rbs_read_burst_sequencing rbs_read_burst_sequencing_i (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cmd_pins, .rd_drive,
		.rd_pair_index, .rd_chopped, .wr_capture, .wr_pair_index, .wr_chopped);
	rbs_ctrl_model rbs_ctrl_model_i (.pclk, .cmd_pins);
	// Free-running clock
	initial
	begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	task automatic cmp(input logic [32:0] e, g);
		total_checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("[ERR] %0t want %h got %h", $time, e, g);
		end
	endtask : cmp
	// Register bus answers: error flag over read data
	task automatic cmp_bus(input logic [32:0] e, g);
		cmp(e, g);
	endtask : cmp_bus
	// Burst kind flag at the first pair of a burst
	task automatic cmp_burst(input logic [32:0] e, g);
		cmp(e, g);
	endtask : cmp_burst
	// Cycle counts and leftover notes
	task automatic cmp_count(input logic [32:0] e, g);
		cmp(e, g);
	endtask : cmp_count
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction : xs
	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : test_done
	// One APB transfer; reads leave a note for the monitor
	task automatic apb(input logic w, input logic [31:0] a, d, input logic [32:0] e);
		if (!w)
			qa.push_back(e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'b1 && k < 9);
		// Judge by the answer itself, so a reply on the last try still counts
		if (pready !== 1'b1)
		begin
			miscompares++;
			test_done();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	// Retire the oldest note of each kind as its result shows
	always @(posedge pclk)
	begin
		if (pready === 1'b1 && pwrite === 1'b0 && qa.size() > 0)
			cmp_bus(qa.pop_front(), {pslverr, prdata});
		if (rd_drive === 1'b1 && rd_pair_index === 2'h0 && qr.size() > 0)
			cmp_burst(qr.pop_front(), rd_chopped);
		if (wr_capture === 1'b1 && wr_pair_index === 2'h0 && qw.size() > 0)
			cmp_burst(qw.pop_front(), wr_chopped);
	end
	// Main sequence
	initial
	begin
		{presetn, psel, penable, pwrite, p, paddr, pwdata} = '0;
		rnd = 32'h15;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, RBS_MODE_OFFSET, 0, {1'b0, RBS_MODE_RESET});
		apb(0, 32'h0C, 0, {1'b1, 32'h0});
		$display("test reset done");
		// Each field with both chop levels, read then write
		// Field 11 is run too; it must behave as eight beats
		for (int f = 0; f < 4; f++)
			for (int c = 0; c < 2; c++)
			begin
				rnd = xs(rnd);
				apb(1, RBS_MODE_OFFSET, RBS_MODE_RESET | 32'(f), 0);
				qr.push_back(33'(f == 2 || (f == 1 && c == 0)));
				qw.push_back(33'(f == 2 || (f == 1 && c == 0)));
				rbs_ctrl_model_i.issue(0, c[0], rnd[1:0], 1);
				rbs_ctrl_model_i.issue(1, c[0], rnd[3:2], 6);
				repeat (20) @(posedge pclk);
			end
		$display("test fields done");
		// Reads four apart under long read preamble
		apb(1, RBS_MODE_OFFSET, RBS_MODE_RESET | 32'h4, 0);
		qr.push_back(33'h0);
		qr.push_back(33'h0);
		rbs_ctrl_model_i.issue(0, 1, 2'h0, 1);
		rbs_ctrl_model_i.issue(0, 1, 2'h1, 4);
		{n, r} = '0;
		repeat (30)
		begin
			@(posedge pclk);
			r += int'(rd_drive === 1'b1 && p === 1'b0);
			n += int'(rd_drive === 1'b1);
			p = rd_drive;
		end
		cmp_count(33'h8, n);
		cmp_count(33'h1, r);
		$display("test stream done");
		// long write preamble, latency one above lowest, then at lowest
		apb(1, RBS_MODE_OFFSET, 32'h000A_0B08, 0);
		apb(0, RBS_STATUS_OFFSET, 0, 33'h0);
		apb(1, RBS_MODE_OFFSET, 32'h0009_0B08, 0);
		apb(0, RBS_STATUS_OFFSET, 0, 33'h2);
		// Eight reads in the field loop, two in the stream test
		apb(0, RBS_COUNT_OFFSET, 0, 33'hA);
		cmp_count(33'h0, qa.size() + qr.size() + qw.size());
		$display("test preamble done");
		test_done();
	end
endmodule : tb_read_burst_sequencing
